// ### core/gpm_mux.sv
// output-source multiplexer for two general pins and the mute pin
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`default_nettype none
`include "gpm_regs.svh"
module gpm_mux
	import gpm_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// avalon-mm slave, word addressed
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	// source flags from other units
	input  wire gpm_src_t    src,
	// pin drive
	output var  logic        general_pin_zero_o,
	output var  logic        general_pin_zero_oe,
	output var  logic        general_pin_two_o,
	output var  logic        general_pin_two_oe,
	output var  logic        soft_mute_pin_o
);
	// register state
	logic [7:0]  sel0_q;     // pin zero select
	logic [7:0]  sel2_q;     // pin two select
	logic [7:0]  lvl_q;      // software levels
	logic [7:0]  dir_q;      // direction bits
	logic [7:0]  selm_q;     // mute pin select
	gpm_bus_t    st_q;       // bus state
	logic [31:0] rdata_q;    // read data register
	logic        p0_q, p2_q, pm_q, oe0_q, oe2_q;

	// five-bit codes from the select registers
	wire [4:0] pin0_source_code = sel0_q[`GPM_SEL_MSB:0];
	wire [4:0] pin2_source_code = sel2_q[`GPM_SEL_MSB:0];
	wire [4:0] mute_source_code = selm_q[`GPM_SEL_MSB:0];
	wire       pin0_level_bit   = lvl_q[`GPM_LVL_PIN0];
	wire       pin2_level_bit   = lvl_q[`GPM_LVL_PIN2];
	wire       mute_level_bit   = lvl_q[`GPM_LVL_MUTE];

	// source table, shared by all three pins
	function automatic logic pick(input logic [4:0] c, input gpm_src_t s,
		input logic lv);
		case (c)
			`GPM_C_REGOUT:     pick = lv;
			`GPM_C_CLKINV:     pick = s.clk_err | s.clk_chg | s.clk_miss;
			`GPM_C_SERIAL_AUDIO_DATA_OUT:      pick = s.serial_audio_data_out;
			`GPM_C_AMUTE_L:    pick = s.amute_l_n;
			`GPM_C_AMUTE_R:    pick = s.amute_r_n;
			`GPM_C_PLL_LOCK:   pick = s.pll_lock;
			`GPM_C_CP_CLK:     pick = s.cp_clk;
			`GPM_C_UV_HI:      pick = s.uv_hi;
			`GPM_C_UV_LO:      pick = s.uv_lo;
			`GPM_C_PLL_DIV4:   pick = s.pll_div4;
			`GPM_C_OSC_DIV4:   pick = s.osc_div4;
			`GPM_C_IMP_L:      pick = s.imp_l;
			`GPM_C_IMP_R:      pick = s.imp_r;
			`GPM_C_UVP:        pick = s.undervoltage_protect_flag;
			`GPM_C_CAL:        pick = s.cal_busy;
			`GPM_C_CLK_ERR:    pick = s.clk_err;
			`GPM_C_CLK_CHG:    pick = s.clk_chg;
			`GPM_C_CLK_MISS:   pick = s.clk_miss;
			`GPM_C_CLK_HALT:   pick = s.clk_halt;
			`GPM_C_BOOT:       pick = s.boot_done;
			`GPM_C_CP_VALID_N: pick = s.cp_valid_n;
			default:           pick = 1'b0;
		endcase
	endfunction

	// selected levels, before registering
	wire nxt0 = pick(pin0_source_code, src, pin0_level_bit);
	wire nxt2 = pick(pin2_source_code, src, pin2_level_bit);
	wire nxtm = pick(mute_source_code, src, mute_level_bit);

	// bus decode
	wire       is_idle  = (st_q == GPM_IDLE);
	// writes land at the acknowledge edge, while the master still holds
	wire       wr_go    = (st_q == GPM_ACK) & avs_write;
	wire       rd_go    = is_idle & avs_read;
	wire [7:0] wb       = avs_writedata[7:0];
	wire       hit_s0   = (avs_address == `GPM_OFS_PIN0_SEL);
	wire       hit_s2   = (avs_address == `GPM_OFS_PIN2_SEL);
	wire       hit_lv   = (avs_address == `GPM_OFS_LEVEL);
	wire       hit_dir  = (avs_address == `GPM_OFS_DIR);
	wire       hit_sm   = (avs_address == `GPM_OFS_MUTE_SEL);
	// unmapped addresses read zero, writes dropped
	wire [7:0] rd_byte  = hit_s0 ? sel0_q : hit_s2 ? sel2_q :
		hit_lv ? lvl_q : hit_dir ? dir_q : hit_sm ? selm_q : 8'h00;

	// one wait cycle then acknowledge; the request is taken in idle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= GPM_IDLE;
		end else begin
			case (st_q)
				GPM_IDLE: st_q <= (avs_read | avs_write) ? GPM_ACK : GPM_IDLE;
				GPM_ACK:  st_q <= GPM_IDLE;
				default:  st_q <= GPM_IDLE;
			endcase
		end
	end

	// waitrequest low only in the acknowledge cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(is_idle & (avs_read | avs_write));
		end
	end

	// read data captured one cycle ahead of the acknowledge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_go) begin
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end
	assign avs_readdata = rdata_q;

	// select and level registers, all eight bits kept
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel0_q <= `GPM_RST_REG;
			sel2_q <= `GPM_RST_REG;
			lvl_q  <= `GPM_RST_REG;
			dir_q  <= `GPM_RST_REG;
			selm_q <= `GPM_RST_REG;
		end else if (wr_go) begin
			if (hit_s0)
				sel0_q <= wb;
			if (hit_s2)
				sel2_q <= wb;
			if (hit_lv)
				lvl_q <= wb;
			if (hit_dir)
				dir_q <= wb;
			if (hit_sm)
				selm_q <= wb;
		end
	end

	// registered pin levels avoid mux glitches on reselect
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			p0_q  <= 1'b0;
			p2_q  <= 1'b0;
			pm_q  <= 1'b0;
			oe0_q <= 1'b0;
			oe2_q <= 1'b0;
		end else begin
			p0_q  <= nxt0 & dir_q[`GPM_DIR_PIN0];
			p2_q  <= nxt2 & dir_q[`GPM_DIR_PIN2];
			pm_q  <= nxtm;
			oe0_q <= dir_q[`GPM_DIR_PIN0];
			oe2_q <= dir_q[`GPM_DIR_PIN2];
		end
	end
	// value low while not driven, gated before the flop
	assign general_pin_zero_o  = p0_q;
	assign general_pin_zero_oe = oe0_q;
	assign general_pin_two_o   = p2_q;
	assign general_pin_two_oe  = oe2_q;
	assign soft_mute_pin_o     = pm_q;

	// checks
	property p_sel0_ret;
		@(posedge clk) disable iff (!rst_b)
		(wr_go && hit_s0) |=> (sel0_q == $past(wb));
	endproperty
	a_sel0_ret: assert property (p_sel0_ret) else $error("sel0 lost");
	property p_oe0;
		@(posedge clk) disable iff (!rst_b)
		!dir_q[`GPM_DIR_PIN0] |=> !general_pin_zero_oe;
	endproperty
	a_oe0: assert property (p_oe0) else $error("pin0 driven");
	property p_oe2;
		@(posedge clk) disable iff (!rst_b)
		dir_q[`GPM_DIR_PIN2] |=> general_pin_two_oe;
	endproperty
	a_oe2: assert property (p_oe2) else $error("pin2 not driven");
	property p_clkinv;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_CLKINV) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o ==
		($past(src.clk_err) | $past(src.clk_chg) | $past(src.clk_miss));
	endproperty
	a_clkinv: assert property (p_clkinv) else $error("clkinv");
	property p_serial_audio_data_out;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_SERIAL_AUDIO_DATA_OUT) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(src.serial_audio_data_out);
	endproperty
	a_serial_audio_data_out: assert property (p_serial_audio_data_out) else $error("serial_audio_data_out");
	property p_res;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code inside {5'h0C, 5'h0D, 5'h1C, 5'h00})
		|=> !general_pin_zero_o;
	endproperty
	a_res: assert property (p_res) else $error("reserved not zero");
	property p_lvl2;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_REGOUT) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(pin2_level_bit);
	endproperty
	a_lvl2: assert property (p_lvl2) else $error("pin2 level");
	property p_lvlm;
		@(posedge clk) disable iff (!rst_b)
		(mute_source_code == `GPM_C_REGOUT)
		|=> soft_mute_pin_o == $past(mute_level_bit);
	endproperty
	a_lvlm: assert property (p_lvlm) else $error("mute level");
	property p_ack;
		@(posedge clk) disable iff (!rst_b)
		(is_idle && avs_read) |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("bus timing");
	property p_amute_l;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_AMUTE_L) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o == $past(src.amute_l_n);
	endproperty
	a_amute_l: assert property (p_amute_l) else $error("left mute");
	property p_amute_r;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_AMUTE_R) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(src.amute_r_n);
	endproperty
	a_amute_r: assert property (p_amute_r) else $error("right mute");
	property p_lock;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_PLL_LOCK) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o == $past(src.pll_lock);
	endproperty
	a_lock: assert property (p_lock) else $error("lock flag");
	property p_cpclk;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_CP_CLK) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(src.cp_clk);
	endproperty
	a_cpclk: assert property (p_cpclk) else $error("pump clock");
	property p_uvhi;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_UV_HI) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o == $past(src.uv_hi);
	endproperty
	a_uvhi: assert property (p_uvhi) else $error("uv high");
	property p_uvlo;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_UV_LO) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(src.uv_lo);
	endproperty
	a_uvlo: assert property (p_uvlo) else $error("uv low");
	// divided pll clock on pin zero
	property p_plldiv;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_PLL_DIV4) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o == $past(src.pll_div4);
	endproperty
	a_plldiv: assert property (p_plldiv) else $error("pll div");
	property p_oscdiv;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_OSC_DIV4) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(src.osc_div4);
	endproperty
	a_oscdiv: assert property (p_oscdiv) else $error("osc div");
	property p_imp_l;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_IMP_L) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o == $past(src.imp_l);
	endproperty
	a_imp_l: assert property (p_imp_l) else $error("imp left");
	property p_imp_r;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_IMP_R) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(src.imp_r);
	endproperty
	a_imp_r: assert property (p_imp_r) else $error("imp right");
	property p_uvp;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_UVP) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o == $past(src.undervoltage_protect_flag);
	endproperty
	a_uvp: assert property (p_uvp) else $error("protect flag");
	property p_cal;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_CAL) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(src.cal_busy);
	endproperty
	a_cal: assert property (p_cal) else $error("cal flag");
	property p_clkerr;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_CLK_ERR) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o == $past(src.clk_err);
	endproperty
	a_clkerr: assert property (p_clkerr) else $error("clock error");
	property p_halt;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_CLK_HALT) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(src.clk_halt);
	endproperty
	a_halt: assert property (p_halt) else $error("halt flag");
	property p_boot;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_BOOT) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o == $past(src.boot_done);
	endproperty
	a_boot: assert property (p_boot) else $error("boot flag");
	property p_cpv;
		@(posedge clk) disable iff (!rst_b)
		(pin2_source_code == `GPM_C_CP_VALID_N) && dir_q[`GPM_DIR_PIN2]
		|=> general_pin_two_o == $past(src.cp_valid_n);
	endproperty
	a_cpv: assert property (p_cpv) else $error("pump valid");
	property p_lvl0;
		@(posedge clk) disable iff (!rst_b)
		(pin0_source_code == `GPM_C_REGOUT) && dir_q[`GPM_DIR_PIN0]
		|=> general_pin_zero_o == $past(pin0_level_bit);
	endproperty
	a_lvl0: assert property (p_lvl0) else $error("pin0 level");
	c_wr: cover property (@(posedge clk) wr_go && hit_lv);
	c_rd: cover property (@(posedge clk) rd_go && hit_s2);
	c_p0: cover property (@(posedge clk) general_pin_zero_o);
	c_p2: cover property (@(posedge clk) general_pin_two_o);
endmodule
`default_nettype wire

// ### core/gpm_regs.svh
// register offsets, field positions and codes for the pin source mux
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH
`define GPM_OFS_PIN0_SEL   8'h53
`define GPM_OFS_PIN2_SEL   8'h55
`define GPM_OFS_LEVEL      8'h56
`define GPM_OFS_DIR        8'h60
`define GPM_OFS_MUTE_SEL   8'h61
`define GPM_RST_REG        8'h00
`define GPM_SEL_MSB        4
`define GPM_LVL_PIN2       5
`define GPM_LVL_MUTE       4
`define GPM_LVL_PIN0       3
`define GPM_DIR_PIN0       0
`define GPM_DIR_PIN2       2
`define GPM_C_REGOUT       5'h02
`define GPM_C_CLKINV       5'h06
`define GPM_C_SERIAL_AUDIO_DATA_OUT        5'h07
`define GPM_C_AMUTE_L      5'h08
`define GPM_C_AMUTE_R      5'h09
`define GPM_C_PLL_LOCK     5'h0A
`define GPM_C_CP_CLK       5'h0B
`define GPM_C_UV_HI        5'h0E
`define GPM_C_UV_LO        5'h0F
`define GPM_C_PLL_DIV4     5'h10
`define GPM_C_OSC_DIV4     5'h11
`define GPM_C_IMP_L        5'h12
`define GPM_C_IMP_R        5'h13
`define GPM_C_UVP          5'h14
`define GPM_C_CAL          5'h15
`define GPM_C_CLK_ERR      5'h16
`define GPM_C_CLK_CHG      5'h17
`define GPM_C_CLK_MISS     5'h18
`define GPM_C_CLK_HALT     5'h19
`define GPM_C_BOOT         5'h1A
`define GPM_C_CP_VALID_N   5'h1B
`endif

// ### core/gpm_pkg.sv
// types shared by the pin source mux
`default_nettype none
package gpm_pkg;
	// source flags arriving from the other units
	typedef struct packed {
		logic clk_err;
		logic clk_chg;
		logic clk_miss;
		logic serial_audio_data_out;
		logic amute_l_n;
		logic amute_r_n;
		logic pll_lock;
		logic cp_clk;
		logic uv_hi;
		logic uv_lo;
		logic pll_div4;
		logic osc_div4;
		logic imp_l;
		logic imp_r;
		logic undervoltage_protect_flag;
		logic cal_busy;
		logic clk_halt;
		logic boot_done;
		logic cp_valid_n;
	} gpm_src_t;
	// bus access states
	typedef enum logic [1:0] {
		GPM_IDLE = 2'b01,
		GPM_ACK  = 2'b10
	} gpm_bus_t;
endpackage
`default_nettype wire

// ### bench/tb_gpio_output_source_mux.sv
// self-checking random bench for the pin source mux
`default_nettype none
`include "gpm_regs.svh"
module tb_gpio_output_source_mux
	import gpm_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;

// compare, count, report at once
`define CHK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("[ERR] t=%0t got %0h exp %0h", $time, (got), (exp)); \
	end \
end

	logic        clk;             // 125 MHz bench clock
	logic        rst_b;           // async reset, active low
	logic [7:0]  avs_address;     // word index
	logic        avs_read;        // read request
	logic        avs_write;       // write request
	logic [31:0] avs_writedata;   // write data, low byte used
	logic [31:0] avs_readdata;    // read data from slave
	logic        avs_waitrequest; // slave stall
	gpm_src_t    src;             // source flags driven by bench
	logic        p0_o;            // pin zero level
	logic        p0_oe;           // pin zero enable
	logic        p2_o;            // pin two level
	logic        p2_oe;           // pin two enable
	logic        mute_o;          // mute pin level
	int          n_mismatch;      // mismatches seen
	int          check_count;     // comparisons made
	logic [31:0] rd;              // last read data taken
	logic [31:0] r;               // random draw
	logic [7:0]  ofs [5] = '{`GPM_OFS_PIN0_SEL, `GPM_OFS_PIN2_SEL,
		`GPM_OFS_LEVEL, `GPM_OFS_DIR, `GPM_OFS_MUTE_SEL};

	// design under test, driven by the bench alone
	gpm_mux u_dut (
		.clk                 (clk),
		.rst_b               (rst_b),
		.avs_address         (avs_address),
		.avs_read            (avs_read),
		.avs_write           (avs_write),
		.avs_writedata       (avs_writedata),
		.avs_readdata        (avs_readdata),
		.avs_waitrequest     (avs_waitrequest),
		.src                 (src),
		.general_pin_zero_o  (p0_o),
		.general_pin_zero_oe (p0_oe),
		.general_pin_two_o   (p2_o),
		.general_pin_two_oe  (p2_oe),
		.soft_mute_pin_o     (mute_o)
	);

	// free-running clock, 8 ns period
	always #4 clk = ~clk;

	// expected pin level for a source code
	function automatic logic pick(input logic [4:0] c, input gpm_src_t s,
		input logic lv);
		case (c)
			5'h02: pick = lv;
			5'h06: pick = s.clk_err | s.clk_chg | s.clk_miss;
			5'h07: pick = s.serial_audio_data_out;
			5'h08: pick = s.amute_l_n;
			5'h09: pick = s.amute_r_n;
			5'h0A: pick = s.pll_lock;
			5'h0B: pick = s.cp_clk;
			5'h0E: pick = s.uv_hi;
			5'h0F: pick = s.uv_lo;
			5'h10: pick = s.pll_div4;
			5'h11: pick = s.osc_div4;
			5'h12: pick = s.imp_l;
			5'h13: pick = s.imp_r;
			5'h14: pick = s.undervoltage_protect_flag;
			5'h15: pick = s.cal_busy;
			5'h16: pick = s.clk_err;
			5'h17: pick = s.clk_chg;
			5'h18: pick = s.clk_miss;
			5'h19: pick = s.clk_halt;
			5'h1A: pick = s.boot_done;
			5'h1B: pick = s.cp_valid_n;
			// reserved codes, 1100 and 1101 among them, give zero
			default: pick = 1'b0;
		endcase
	endfunction

	// verdict and end of run, also reached on a hang
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		int i;
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		avs_write     <= wr;
		avs_read      <= ~wr;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 16);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		// a stuck slave ends the run
		if (avs_waitrequest !== 1'b0) begin
			n_mismatch++;
			results();
		end
	endtask

	// let the registered pins settle, then compare all three
	task automatic pins(input logic [4:0] c0, input logic [4:0] c2,
		input logic [4:0] cm, input logic [7:0] lv, input logic [7:0] dr);
		repeat (3) @(posedge clk);
		`CHK(p0_oe, dr[0])
		`CHK(p0_o, dr[0] & pick(c0, src, lv[3]))
		`CHK(p2_oe, dr[2])
		`CHK(p2_o, dr[2] & pick(c2, src, lv[5]))
		`CHK(mute_o, pick(cm, src, lv[4]))
	endtask

	// main sequence
	initial begin
		logic [4:0] c0;
		logic [4:0] c2;
		logic [4:0] cm;
		logic [7:0] lv;
		logic [7:0] dr;
		clk = 1'b0;
		rst_b = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		src = '0;
		n_mismatch = 0;
		check_count = 0;
		r = $urandom(32'hF665);
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		// reset values, then full-byte readback with reserved bits
		foreach (ofs[i]) begin
			bus(1'b0, ofs[i], 8'h00);
			`CHK(rd, 32'h00000000)
			r = $urandom;
			bus(1'b1, ofs[i], r[7:0]);
			bus(1'b0, ofs[i], 8'h00);
			`CHK(rd, {24'h000000, r[7:0]})
		end
		// unmapped place: write dropped, read gives zero
		bus(1'b1, 8'h54, 8'hFF);
		bus(1'b0, 8'h54, 8'h00);
		`CHK(rd, 32'h00000000)
		// sweep all codes, pins enabled then disabled
		for (int p = 0; p < 2; p++) begin
			dr = (p == 0) ? 8'h05 : 8'h00;
			bus(1'b1, `GPM_OFS_DIR, dr);
			for (int c = 0; c < 32; c++) begin
				c0 = 5'(c);
				c2 = 5'h1F - c0;
				cm = c0 + 5'h07;
				r = $urandom;
				lv = r[15:8];
				bus(1'b1, `GPM_OFS_PIN0_SEL, {r[2:0], c0});
				bus(1'b1, `GPM_OFS_PIN2_SEL, {r[5:3], c2});
				bus(1'b1, `GPM_OFS_MUTE_SEL, {r[7:5], cm});
				bus(1'b1, `GPM_OFS_LEVEL, lv);
				// all-zero and all-one flags, then random ones
				for (int k = 0; k < 4; k++) begin
					r = $urandom;
					src <= (k == 0) ? '0 : (k == 1) ? '1 : r[18:0];
					pins(c0, c2, cm, lv, dr);
				end
			end
		end
		results();
	end

endmodule
`default_nettype wire
